/* core/gbs_gpio.sv */
// general-purpose pins with a boot strap on one pin and two card power muxes
// assumes pin inputs synchronous to clk; firmware drives cfg and clears events
//
// What this block does
// - each pin is set by firmware as input, edge interrupt input or driven output.
// - while reset is held the weak pull-up on the boot strap pin is on.
// - the boot strap pull-up turns off a few clocks after reset rises.
// - the boot strap level is caught at the first clock after reset release to pick the code memory.
// - the caught strap level is kept in internal_code_select_bit; the input status bits follow the live pins.
// - a high strap level selects internal program memory.
// - once strap_done is set the boot strap pin works as a normal general-purpose pin.
// - two pins can each be switched to drive card power instead.
`timescale 1ns/10ps
module gbs_gpio (
   // clock and reset
   input  wire logic                        clk,
   input  wire logic                        nrst,
   // firmware configuration
   input  wire gbs_pkg::gbs_cfg_t [8:0]     cfg,
   input  wire logic [1:0]                  pwr_sel,
   input  wire logic [1:0]                  pwr_on,
   input  wire logic [8:0]                  evt_clr,
   // pads
   input  wire logic [8:0]                  pin_in,
   output logic [8:0]                       pin_out,
   output logic [8:0]                       pin_oe,
   output logic                             strap_pullup,
   // status to firmware
   output logic [8:0]                       pin_input_status,
   output logic [8:0]                       evt,
   output logic                             irq,
   output logic                             internal_code_select_bit,
   output logic                             strap_done
);
   import gbs_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // local types and decode helpers
   // the pins share one decode; only the strap pin and the two card power
   // pins differ, and those differences are picked by pin index

   // strap sequence after reset release
   typedef enum logic [1:0] {
      GBS_ST_CATCH = 2'b00,  // first edge after release, pin still pulled up
      GBS_ST_COUNT = 2'b01,  // pull-up kept on while the counter runs
      GBS_ST_DONE  = 2'b10,  // pull-up off, strap pin handed to firmware
      GBS_ST_SPARE = 2'b11   // never entered; falls through to done
   } gbs_strap_st_t;

   // true when pin idx is switched over to card power
   function automatic logic is_pwr(input int idx, input logic [1:0] sel);
      is_pwr = (idx == GBS_PWR0_IDX && sel[0]) || (idx == GBS_PWR1_IDX && sel[1]);
   endfunction

   // card power level for pin idx; only meaningful where is_pwr holds
   function automatic logic pwr_bit(input int idx, input logic [1:0] on);
      pwr_bit = (idx == GBS_PWR0_IDX) ? on[0] : on[1];
   endfunction

   // edge detect on one pin for the selected polarity
   function automatic logic edge_seen(input logic rise, input logic now, input logic was);
      edge_seen = rise ? (now & ~was) : (~now & was);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // strap sequencing
   // the caught level is loaded by the first clock after release rather
   // than by the reset edge itself: an async reset flop may only load a
   // constant, and the pull-up is still on at that clock, so an open pin
   // reads high there and selects internal memory
   // limitation: a board that needs the pull-up longer than the hold count
   // must strap with its own resistor

   gbs_strap_st_t  strap_state;
   gbs_strap_st_t  next_strap_state;
   logic [3:0]     pu_cnt;
   logic [3:0]     next_pu_cnt;
   logic           pu_full;
   logic           catch_now;
   logic           captured;
   logic           next_code_sel;

   // counter saturates at the hold count, so it never wraps back
   assign pu_full     = (pu_cnt == GBS_PU_CYC);
   assign next_pu_cnt = pu_full ? pu_cnt : pu_cnt + 4'h1;

   // state decode shared by the capture and the pin logic
   assign catch_now = (strap_state == GBS_ST_CATCH);
   assign captured  = !catch_now;

   // strap level loads once; later pin activity leaves it alone
   assign next_code_sel = catch_now ? pin_in[GBS_STRAP_IDX]
                                    : internal_code_select_bit;

   // next state of the strap sequence
   always_comb begin
      case (strap_state)
         GBS_ST_CATCH: begin
            if (next_pu_cnt == GBS_PU_CYC) begin
               next_strap_state = GBS_ST_DONE;
            end else begin
               next_strap_state = GBS_ST_COUNT;
            end
         end
         GBS_ST_COUNT: begin
            if (next_pu_cnt == GBS_PU_CYC) begin
               next_strap_state = GBS_ST_DONE;
            end else begin
               next_strap_state = GBS_ST_COUNT;
            end
         end
         GBS_ST_DONE: begin
            next_strap_state = GBS_ST_DONE;
         end
         default: begin
            next_strap_state = GBS_ST_DONE;
         end
      endcase
   end

   // strap registers; pull-up on in reset, dropped when the count is reached
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         strap_state              <= GBS_ST_CATCH;
         pu_cnt                   <= 4'h0;
         strap_pullup             <= 1'b1;
         strap_done               <= 1'b0;
         internal_code_select_bit <= 1'b1;
      end else begin
         strap_state              <= next_strap_state;
         pu_cnt                   <= next_pu_cnt;
         strap_pullup             <= (next_strap_state != GBS_ST_DONE);
         strap_done               <= (next_strap_state == GBS_ST_DONE);
         internal_code_select_bit <= next_code_sel;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // per-pin logic
   // outputs are registered, so a mode change shows on the pad one clock
   // later; this costs a cycle but keeps the pads glitch free

   logic [8:0] prev_in;
   logic [8:0] next_out;
   logic [8:0] next_oe;
   logic [8:0] next_evt;
   logic [8:0] pin_is_out;
   logic [8:0] pin_is_irq;
   logic [8:0] pin_is_pwr;
   logic [8:0] pin_hold;
   logic [8:0] edge_hit;

   genvar gi;
   generate
      for (gi = 0; gi < GBS_NPIN; gi++) begin : g_pin
         // mode decode; the spare mode code behaves as a plain input
         assign pin_is_out[gi] = (cfg[gi].mode == GBS_OUT);
         assign pin_is_irq[gi] = (cfg[gi].mode == GBS_IRQ);

         // card power overrides the firmware drive on the two shared pins
         assign pin_is_pwr[gi] = is_pwr(gi, pwr_sel);

         // strap pin stays undriven until the pull-up is let go, so a
         // driven level can not fight the strap resistor
         assign pin_hold[gi]   = (gi == GBS_STRAP_IDX) && !strap_done;

         // no edge on the first clock after reset: prev_in holds no sample
         assign edge_hit[gi]   = pin_is_irq[gi] && captured &&
                                 edge_seen(cfg[gi].rise, pin_in[gi], prev_in[gi]);

         // pad drive selection
         assign next_out[gi]   = pin_is_pwr[gi] ? pwr_bit(gi, pwr_on) : cfg[gi].dout;
         assign next_oe[gi]    = !pin_hold[gi] && (pin_is_pwr[gi] || pin_is_out[gi]);

         // set wins over clear, so an edge in the clearing cycle is kept
         assign next_evt[gi]   = edge_hit[gi] | (evt[gi] & ~evt_clr[gi]);
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // pad registers and status
   // irq is built from next_evt so that it lines up with evt exactly

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         prev_in          <= GBS_ZERO9;
         pin_out          <= GBS_ZERO9;
         pin_oe           <= GBS_ZERO9;
         pin_input_status <= GBS_ZERO9;
         evt              <= GBS_ZERO9;
         irq              <= 1'b0;
      end else begin
         prev_in          <= pin_in;
         pin_out          <= next_out;
         pin_oe           <= next_oe;
         pin_input_status <= pin_in;
         evt              <= next_evt;
         irq              <= |next_evt;
      end
   end
endmodule // gbs_gpio

/* core/gbs_pkg.sv */
// shared constants and carrier types for the gpio port with boot strap
// assumes one 25 MHz clock and an active-low asynchronous chip reset
package gbs_pkg;
   localparam int          GBS_NPIN        = 9;  // pins 1,2,4,5,6,7,8,9,10
   localparam int          GBS_STRAP_IDX   = 4;  // boot strap pin position
   localparam int          GBS_PWR0_IDX    = 6;  // shares card power zero
   localparam int          GBS_PWR1_IDX    = 8;  // shares card power one
   localparam int          GBS_CLK_MHZ     = 25;
   localparam int          GBS_PU_HOLD_NS  = 160; // pull-up kept after release
   localparam logic [3:0]  GBS_PU_CYC      = 4'((GBS_PU_HOLD_NS * GBS_CLK_MHZ + 999) / 1000);
   localparam logic [1:0]  GBS_MODE_RST    = 2'h0;
   localparam logic [8:0]  GBS_ZERO9       = 9'h000;

   // per-pin operating mode
   typedef enum logic [1:0] {
      GBS_IN   = 2'b00,
      GBS_IRQ  = 2'b01,
      GBS_OUT  = 2'b10,
      GBS_RSV  = 2'b11
   } gbs_mode_t;

   // per-pin configuration from firmware
   typedef struct packed {
      gbs_mode_t  mode;
      logic       rise;   // 1 = rising edge interrupt, 0 = falling
      logic       dout;
   } gbs_cfg_t;

   // pad drive for one pin
   typedef struct packed {
      logic  o;
      logic  oe;
   } gbs_pad_t;
endpackage

/* test/gbs_checker.sv */
// concurrent checks on the gpio port with boot strap
// assumes it is bound to gbs_gpio, one clock domain
`timescale 1ns/10ps
module gbs_checker (
   // clock and reset
   input  wire logic                    clk,
   input  wire logic                    nrst,
   // firmware side
   input  wire gbs_pkg::gbs_cfg_t [8:0] cfg,
   input  wire logic [1:0]              pwr_sel,
   input  wire logic [1:0]              pwr_on,
   // pads
   input  wire logic [8:0]              pin_in,
   input  wire logic [8:0]              pin_out,
   input  wire logic [8:0]              pin_oe,
   input  wire logic                    strap_pullup,
   // status
   input  wire logic [8:0]              pin_input_status,
   input  wire logic [8:0]              evt,
   input  wire logic                    irq,
   input  wire logic                    internal_code_select_bit,
   input  wire logic                    strap_done
);
   import gbs_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   property p_out;
      cfg[0].mode == GBS_OUT |=> pin_oe[0] && pin_out[0] == $past(cfg[0].dout);
   endproperty
   a_out: assert property (p_out) else $error("output pin not driven");
   property p_in;
      cfg[1].mode == GBS_IN |=> !pin_oe[1];
   endproperty
   a_in: assert property (p_in) else $error("input pin driven");
   property p_irq;
      irq == (|evt);
   endproperty
   a_irq: assert property (p_irq) else $error("irq not the or of events");
   property p_evt;
      $past(nrst) && cfg[2].mode == GBS_IRQ && cfg[2].rise && $rose(pin_in[2]) |=> evt[2];
   endproperty
   a_evt: assert property (p_evt) else $error("rising edge event missed");
   property p_pwr;
      pwr_sel[1] |=> pin_oe[8] && pin_out[8] == $past(pwr_on[1]);
   endproperty
   a_pwr: assert property (p_pwr) else $error("card power not on pin");
   property p_hid;
      !strap_done |-> !pin_oe[4];
   endproperty
   a_hid: assert property (p_hid) else $error("strap pin driven early");
   property p_st;
      1 |=> pin_input_status == $past(pin_in);
   endproperty
   a_st: assert property (p_st) else $error("input status wrong");
   property p_keep;
      strap_done |=> $stable(internal_code_select_bit);
   endproperty
   a_keep: assert property (p_keep) else $error("code select moved");
   property p_pu;
      $fell(strap_pullup) |-> $rose(strap_done);
   endproperty
   a_pu: assert property (p_pu) else $error("pull-up release mistimed");
endmodule // gbs_checker
bind gbs_gpio gbs_checker u_chk (.clk, .nrst, .strap_pullup, .strap_done, .irq,
   .internal_code_select_bit, .cfg, .pwr_sel, .pwr_on, .pin_in, .pin_out, .pin_oe,
   .pin_input_status, .evt);

/* test/gbs_board.sv */
// board model: strap resistor and far-side pad levels
// assumes the bench sets the far-side levels in ext
`timescale 1ns/10ps
module gbs_board (
   // pad drive from the block
   input  wire logic [8:0] pin_out,
   input  wire logic [8:0] pin_oe,
   // far-side levels
   input  wire logic [8:0] ext,
   input  wire logic       strap_open,
   input  wire logic       strap_pullup,
   // pad levels seen by the block
   output logic      [8:0] pin_in
);
   // an open strap reads only what the weak pull-up gives
   always_comb begin
      pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
      if (strap_open && !pin_oe[4]) pin_in[4] = strap_pullup;
   end
endmodule // gbs_board

/* test/gpio_with_boot_strap_tb.sv */
// self-checking bench for gbs_gpio against an integer model
// assumes gbs_board on the pads and the bound checker
`timescale 1ns/10ps
module gpio_with_boot_strap_tb;
   import gbs_pkg::*;
   logic             clk = 0, nrst = 0, sopen = 1, run = 0, p, e, m_first;
   logic             strap_pullup, strap_done, irq, ics;
   gbs_cfg_t   [8:0] cfg = '0;
   logic       [1:0] pwr_sel = 2'h0, pwr_on = 2'h0;
   logic       [8:0] evt_clr = 9'h000, ext = 9'h000, pin_in, pin_out, pin_oe, st, evt;
   logic       [8:0] m_oe, m_out, m_st, m_evt, m_prev;
   int               err_total = 0, cmp_count = 0, n;
   always #20 clk = ~clk;
   gbs_gpio dut (.clk, .nrst, .cfg, .pwr_sel, .pwr_on, .evt_clr, .pin_in, .pin_out, .pin_oe,
      .strap_pullup, .pin_input_status(st), .evt, .irq, .internal_code_select_bit(ics),
      .strap_done);
   gbs_board u_brd (.pin_out, .pin_oe, .ext, .strap_open(sopen), .strap_pullup, .pin_in);
   task automatic chk(input logic [8:0] s, x);
      cmp_count++;
      if (s !== x) begin
         err_total++;
         $display("MISMATCH %0t seen %h want %h", $time, s, x);
      end
   endtask
   task automatic finish_test;
      if (err_total == 0 && cmp_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic rst(input logic s);
      sopen = s;
      nrst = 0;
      repeat (16) @(posedge clk);
      chk({8'h00, strap_pullup & ics}, 9'h001);
      #1 nrst = 1;
   endtask
   // reference model; set wins over clear, first edge after reset counts nothing
   always @(posedge clk or negedge nrst) if (!nrst) {m_evt, m_st, m_oe, m_out, m_first} <= '1 >> 36;
   else begin
      m_first <= 0; m_prev <= pin_in; m_st <= pin_in;
      for (int i = 0; i < 9; i++) begin
         p = (i == 6 && pwr_sel[0]) || (i == 8 && pwr_sel[1]);
         e = cfg[i].rise ? pin_in[i] & !m_prev[i] : !pin_in[i] & m_prev[i];
         m_oe[i] <= p || cfg[i].mode == GBS_OUT;
         m_out[i] <= p ? pwr_on[i/7] : cfg[i].dout;
         m_evt[i] <= (m_evt[i] & !evt_clr[i]) | (!m_first && cfg[i].mode == GBS_IRQ && e);
      end
   end
   always @(negedge clk) if (run) begin
      chk(pin_oe, m_oe);
      chk(pin_out & pin_oe, m_out & m_oe);
      chk(st, m_st);
      chk(evt, m_evt);
      chk({8'h00, irq}, {8'h00, |m_evt});
   end
   // watchdog: the run needs about 82 us
   initial begin
      #200000 err_total++;
      finish_test;
   end
   initial begin
      void'($urandom(32'hcf70f0e0));
      rst(1);
      for (n = 0; strap_pullup === 1'b1 && n < 20; n++) begin
         @(posedge clk);
         #1;
      end
      chk(9'(n), 9'(GBS_PU_CYC));
      chk({8'h00, ics}, 9'h001);
      rst(0);
      @(posedge clk) #1 ext = 9'h1ff;
      repeat (8) @(negedge clk);
      chk({8'h00, ics}, 9'h000);
      run = 1;
      repeat (2000) @(posedge clk) begin
         #1 cfg = 36'({$urandom, $urandom});
         {ext, evt_clr, pwr_sel, pwr_on} = 22'($urandom & ($urandom | 32'h3ffe00));
         if (pwr_sel[0]) cfg[6].mode = GBS_OUT;
         if (pwr_sel[1]) cfg[8].mode = GBS_OUT;
      end
      finish_test;
   end
endmodule // gpio_with_boot_strap_tb
